// ---- pcl_pkg.sv ----
package pcl_pkg;
  localparam logic [7:0] PCL_P1_CTL_A_ADDR = 8'h1c;
  localparam logic [7:0] PCL_P1_CTL_B_ADDR = 8'h1d;
  localparam logic [7:0] PCL_P2_CTL_A_ADDR = 8'h2c;
  localparam logic [7:0] PCL_P2_CTL_B_ADDR = 8'h2d;
  localparam logic [7:0] PCL_P3_CTL_A_ADDR = 8'h3c;
  localparam logic [7:0] PCL_P3_CTL_B_ADDR = 8'h3d;
  // first control register fields
  localparam int PCL_A_AN_EN   = 7;
  localparam int PCL_A_SPEED   = 6;
  localparam int PCL_A_DUPLEX  = 5;
  localparam int PCL_A_ADV_FC  = 4;
  localparam int PCL_A_ADV_MSB = 3;
  localparam logic [3:0] PCL_A_ADV_RST = 4'hf;
  // second control register fields
  localparam int PCL_B_LED_OFF = 7;
  localparam int PCL_B_TXDIS   = 6;
  localparam int PCL_B_RESTART = 5;
  localparam int PCL_B_FEF_DIS = 4;
  localparam int PCL_B_PWRDN   = 3;
  localparam int PCL_B_XO_DIS  = 2;
  localparam int PCL_B_FRC_MDI = 1;
  localparam int PCL_B_LOOP    = 0;
  localparam logic [7:0] PCL_B_RST_BASE = 8'h00;
  localparam int PCL_NPORT = 2;
  localparam int PCL_NLED  = 4;
  localparam int PCL_NSTRAP = 11;
endpackage : pcl_pkg

// ---- pcl_port_if.sv ----
`timescale 1ns/1ps
interface pcl_port_if;
  logic       wr_a;     // write strobe, first control register
  logic       wr_b;     // write strobe, second control register
  logic [7:0] wdata;    // write data
  logic       st_an;    // reset value of autoneg enable
  logic       st_spd;   // reset value of forced speed
  logic       st_dpx;   // reset value of forced duplex
  logic       st_fc;    // reset value of pause advertise
  logic       st_xdis;  // reset value of crossover disable
  logic       st_xfrc;  // reset value of forced mdi
  logic [7:0] ctl_a;    // first control register contents
  logic [7:0] ctl_b;    // second control register contents
  modport bank (output wr_a, wr_b, wdata, st_an, st_spd, st_dpx, st_fc, st_xdis, st_xfrc,
                input ctl_a, ctl_b);
  modport port (input wr_a, wr_b, wdata, st_an, st_spd, st_dpx, st_fc, st_xdis, st_xfrc,
                output ctl_a, ctl_b);
endinterface : pcl_port_if

// ---- pcl_port_regs.sv ----
`timescale 1ns/1ps
module pcl_port_regs #(
  parameter bit FIBER = 1'b0
) (
  input  wire logic                           clk,          // system clock
  input  wire logic                           rst,          // sync reset
  pcl_port_if.port                            bus,          // register strobes and contents
  input  wire logic [pcl_pkg::PCL_NLED-1:0]   led_in,       // led drive from status logic
  input  wire logic                           an_failed,    // autoneg ran and failed
  input  wire logic                           auto_mdi,     // auto crossover decision, 1 = mdi
  output logic [pcl_pkg::PCL_NLED-1:0]        led_out,      // led pins
  output logic                                autoneg_en,   // autoneg enabled
  output logic                                speed_100,    // forced rate, 1 = 100 Mbps
  output logic                                full_duplex,  // forced duplex, 1 = full
  output logic                                use_forced_dpx, // forced duplex applies
  output logic [4:0]                          advertise,    // pause,100f,100h,10f,10h
  output logic                                tx_disable,   // transmitter off
  output logic                                an_restart,   // one-cycle restart pulse
  output logic                                fef_disable,  // far-end fault off
  output logic                                power_down,   // phy power down
  output logic                                tx_on_rx_pair, // 1 = mdi pair assignment
  output logic                                loopback      // loopback at this phy
);
  import pcl_pkg::*;
  logic [7:0] ctl_a_r;
  logic [7:0] ctl_b_r;
  logic [7:0] ctl_b_nxt;
  logic [7:0] ctl_a_rst;
  logic [7:0] ctl_b_rst;
  logic       led_off;
  logic       xo_dis;

  assign ctl_a_rst = {bus.st_an, bus.st_spd, bus.st_dpx, bus.st_fc, PCL_A_ADV_RST};
  assign ctl_b_rst = PCL_B_RST_BASE | {5'h00, bus.st_xdis, bus.st_xfrc, 1'b0};
  // restart drops back after one cycle unless written again; a new write wins
  assign ctl_b_nxt = bus.wr_b ? bus.wdata : (ctl_b_r & ~(8'h01 << PCL_B_RESTART));

  always_ff @(posedge clk) begin
    if (rst) begin
      ctl_a_r <= ctl_a_rst;
      ctl_b_r <= ctl_b_rst;
    end else begin
      if (bus.wr_a) begin
        ctl_a_r <= bus.wdata;
      end
      ctl_b_r <= ctl_b_nxt;
    end
  end

  assign bus.ctl_a      = ctl_a_r;
  assign bus.ctl_b      = ctl_b_r;
  assign led_off        = ctl_b_r[PCL_B_LED_OFF];
  assign led_out        = led_off ? {PCL_NLED{1'b1}} : led_in;
  assign autoneg_en     = ctl_a_r[PCL_A_AN_EN];
  assign speed_100      = ctl_a_r[PCL_A_SPEED];
  assign full_duplex    = ctl_a_r[PCL_A_DUPLEX];
  assign use_forced_dpx = ~ctl_a_r[PCL_A_AN_EN] | an_failed;
  assign advertise      = ctl_a_r[PCL_A_ADV_FC:0];
  assign tx_disable     = ctl_b_r[PCL_B_TXDIS];
  assign an_restart     = ctl_b_r[PCL_B_RESTART];
  assign fef_disable    = FIBER & ctl_b_r[PCL_B_FEF_DIS];
  assign power_down     = ctl_b_r[PCL_B_PWRDN];
  assign xo_dis         = ctl_b_r[PCL_B_XO_DIS];
  assign tx_on_rx_pair  = xo_dis ? ctl_b_r[PCL_B_FRC_MDI] : auto_mdi;
  assign loopback       = ctl_b_r[PCL_B_LOOP];
endmodule : pcl_port_regs

// ---- pcl_link_ctl.sv ----
`timescale 1ns/1ps
// What this block does
// - with autoneg off, forced-speed bit 6 picks 100 Mbps when one and 10 Mbps when zero.
// - forced-duplex bit 5 picks full or half duplex when autoneg is off or has failed.
// - forced speed and duplex of each port load from that port's straps during reset.
// - bit 4 advertises pause when set, withholds it when clear, and resets from its strap.
// - bits 3 to 0 advertise 100 full, 100 half, 10 full and 10 half, all resetting to one.
// - led-off bit 7 drives all four led pins of the port high while set.
// - transmitter-disable bit 6 of the second register stops the transmitter, reset zero.
// - writing one to restart bit 5 restarts autoneg on that port, reset zero.
// - bit 4 turns off far-end fault detection and pattern sending, on the first port only.
// - bit 2 disables auto crossover; port 2 resets it from a strap, port 1 to zero.
// - with auto crossover off, bit 1 forces mdi when one and mdi-x when zero.
// - loopback bit 0 of a port loops the other port's traffic at this port's phy.
// - the second register sits at 0x1d and 0x2d; 0x3d is reserved.
// - bit 7 of the first register enables autoneg, else forced bits 6 and 5 apply.
// - the first register sits at 0x1c and 0x2c.
module pcl_link_ctl (
  input  wire logic                    clk,                 // 100 MHz clock
  input  wire logic                    rst,                 // sync reset, active high
  input  wire logic [7:0]              reg_addr,            // register address
  input  wire logic                    reg_wr,              // write strobe
  input  wire logic                    reg_rd,              // read strobe
  input  wire logic [7:0]              reg_wdata,           // write data
  output logic [7:0]                   reg_rdata,           // read data, next cycle
  input  wire logic                    first_port_speed_strap,   // strap pin
  input  wire logic                    second_port_speed_strap,  // strap pin
  input  wire logic                    first_port_duplex_strap,  // strap pin
  input  wire logic                    second_port_duplex_strap, // strap pin
  input  wire logic                    pause_advertise_strap,    // strap pin
  input  wire logic                    second_port_crossover_disable_strap, // strap pin
  input  wire logic                    second_port_crossover_force_strap,   // strap pin
  input  wire logic                    first_port_autoneg_strap,  // strap pin
  input  wire logic                    second_port_autoneg_strap, // strap pin
  input  wire logic [7:0]              led_in,              // led drive, port2 high nibble
  input  wire logic [1:0]              an_failed,           // per port autoneg failed
  input  wire logic [1:0]              auto_mdi,            // per port auto crossover result
  output logic [7:0]                   port_led,            // led pins, port2 high nibble
  output logic [1:0]                   autoneg_en,          // per port autoneg on
  output logic [1:0]                   speed_100,           // per port forced rate
  output logic [1:0]                   full_duplex,         // per port forced duplex
  output logic [1:0]                   use_forced_dpx,      // per port forced duplex applies
  output logic [9:0]                   advertise,           // port2 in high five bits
  output logic [1:0]                   tx_disable,          // per port transmitter off
  output logic [1:0]                   an_restart,          // per port restart pulse
  output logic [1:0]                   fef_disable,         // far-end fault off
  output logic [1:0]                   power_down,          // per port power down
  output logic [1:0]                   tx_on_rx_pair,       // per port mdi assignment
  output logic [1:0]                   loopback_at_phy      // bit n: other port looped at phy n
);
  import pcl_pkg::*;
  logic [PCL_NSTRAP-1:0] strap_pin;
  logic [PCL_NSTRAP-1:0] sync1_r;
  logic [PCL_NSTRAP-1:0] sync2_r;
  logic [PCL_NSTRAP-1:0] sync3_r;
  logic [PCL_NSTRAP-1:0] strap_r;
  logic [PCL_NSTRAP-1:0] strap_nxt;
  logic [7:0]            rdata_r;
  logic [7:0]            rdata_nxt;
  logic [7:0]            ctl_a  [PCL_NPORT];
  logic [7:0]            ctl_b  [PCL_NPORT];
  logic [7:0]            led_o  [PCL_NPORT];

  pcl_port_if pif [PCL_NPORT] ();

  function automatic logic [7:0] addr_a(input int p);
    addr_a = (p == 0) ? PCL_P1_CTL_A_ADDR : PCL_P2_CTL_A_ADDR;
  endfunction : addr_a

  function automatic logic [7:0] addr_b(input int p);
    addr_b = (p == 0) ? PCL_P1_CTL_B_ADDR : PCL_P2_CTL_B_ADDR;
  endfunction : addr_b

  assign strap_pin = {second_port_autoneg_strap, first_port_autoneg_strap,
                      second_port_crossover_force_strap, second_port_crossover_disable_strap,
                      pause_advertise_strap, second_port_duplex_strap,
                      first_port_duplex_strap, second_port_speed_strap,
                      first_port_speed_strap, 2'b00};

  // strap level counts once the second and third stages agree
  genvar g;
  generate
    for (g = 0; g < PCL_NSTRAP; g++) begin : g_strap
      assign strap_nxt[g] = (sync2_r[g] == sync3_r[g]) ? sync3_r[g] : strap_r[g];
    end
  endgenerate

  always_ff @(posedge clk) begin
    sync1_r <= strap_pin;
    sync2_r <= sync1_r;
    sync3_r <= sync2_r;
    strap_r <= strap_nxt;
  end

  generate
    for (g = 0; g < PCL_NPORT; g++) begin : g_port
      assign pif[g].wr_a    = reg_wr & (reg_addr == addr_a(g));
      assign pif[g].wr_b    = reg_wr & (reg_addr == addr_b(g));
      assign pif[g].wdata   = reg_wdata;
      assign pif[g].st_spd  = strap_nxt[2 + g];
      assign pif[g].st_dpx  = strap_nxt[4 + g];
      assign pif[g].st_fc   = strap_nxt[6];
      assign pif[g].st_xdis = (g == 1) ? strap_nxt[7] : 1'b0;
      assign pif[g].st_xfrc = (g == 1) ? strap_nxt[8] : 1'b0;
      assign pif[g].st_an   = strap_nxt[9 + g];
      assign ctl_a[g]       = pif[g].ctl_a;
      assign ctl_b[g]       = pif[g].ctl_b;
      assign port_led[g*PCL_NLED +: PCL_NLED] = led_o[g][PCL_NLED-1:0];
      assign led_o[g][7:PCL_NLED] = '0;

      pcl_port_regs #(
        .FIBER          (g == 0)
      ) u_port (
        .clk            (clk),
        .rst            (rst),
        .bus            (pif[g]),
        .led_in         (led_in[g*PCL_NLED +: PCL_NLED]),
        .an_failed      (an_failed[g]),
        .auto_mdi       (auto_mdi[g]),
        .led_out        (led_o[g][PCL_NLED-1:0]),
        .autoneg_en     (autoneg_en[g]),
        .speed_100      (speed_100[g]),
        .full_duplex    (full_duplex[g]),
        .use_forced_dpx (use_forced_dpx[g]),
        .advertise      (advertise[g*5 +: 5]),
        .tx_disable     (tx_disable[g]),
        .an_restart     (an_restart[g]),
        .fef_disable    (fef_disable[g]),
        .power_down     (power_down[g]),
        .tx_on_rx_pair  (tx_on_rx_pair[g]),
        .loopback       (loopback_at_phy[g])
      );
    end
  endgenerate

  // reserved port 3 locations and unmapped addresses read zero, writes dropped
  assign rdata_nxt = (reg_addr == PCL_P1_CTL_A_ADDR) ? ctl_a[0] :
                     (reg_addr == PCL_P1_CTL_B_ADDR) ? ctl_b[0] :
                     (reg_addr == PCL_P2_CTL_A_ADDR) ? ctl_a[1] :
                     (reg_addr == PCL_P2_CTL_B_ADDR) ? ctl_b[1] : 8'h00;

  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_r <= 8'h00;
    end else if (reg_rd) begin
      rdata_r <= rdata_nxt;
    end
  end

  assign reg_rdata = rdata_r;
endmodule : pcl_link_ctl

// ---- pcl_link_partner.sv ----
`timescale 1ns/1ps
module pcl_link_partner (
  input  wire logic       clk,         // system clock
  input  wire logic       rst,         // sync reset
  input  wire logic [1:0] an_restart,  // restart pulses from the device
  input  wire logic [1:0] autoneg_en,  // device negotiates
  input  wire logic [1:0] fail_cfg,    // partner refuses to agree
  input  wire logic [1:0] mdi_cfg,     // cable wiring seen by auto crossover
  output logic      [1:0] an_failed,   // negotiation outcome
  output logic      [1:0] auto_mdi     // auto crossover decision
);
  logic [1:0] cnt_r [2];
  assign auto_mdi = mdi_cfg;
  // each restart drops the outcome and it settles four cycles later
  always_ff @(posedge clk) begin
    for (int i = 0; i < 2; i++) begin
      if (rst) begin
        cnt_r[i] <= 2'h0;
        an_failed[i] <= 1'b0;
      end else if (an_restart[i]) begin
        cnt_r[i] <= 2'h3;
        an_failed[i] <= 1'b0;
      end else if (cnt_r[i] != 2'h0) begin
        cnt_r[i] <= cnt_r[i] - 2'h1;
      end else begin
        an_failed[i] <= autoneg_en[i] & fail_cfg[i];
      end
    end
  end
endmodule : pcl_link_partner

// ---- pcl_link_ctl_assertions.sv ----
`timescale 1ns/1ps
module pcl_link_ctl_chk (
  input wire logic       clk,             // system clock
  input wire logic       rst,             // sync reset
  input wire logic       reg_wr,          // write strobe
  input wire logic       reg_rd,          // read strobe
  input wire logic [7:0] reg_addr,        // register address
  input wire logic [7:0] reg_wdata,       // write data
  input wire logic [7:0] reg_rdata,       // read data
  input wire logic [7:0] led_in,          // led drive
  input wire logic [7:0] port_led,        // led pins
  input wire logic [9:0] advertise,       // advertised abilities
  input wire logic [1:0] autoneg_en,      // autoneg on
  input wire logic [1:0] speed_100,       // forced rate
  input wire logic [1:0] full_duplex,     // forced duplex
  input wire logic [1:0] use_forced_dpx,  // forced duplex applies
  input wire logic [1:0] an_failed,       // autoneg failed
  input wire logic [1:0] tx_disable,      // transmitter off
  input wire logic [1:0] an_restart,      // restart pulse
  input wire logic [1:0] fef_disable,     // far-end fault off
  input wire logic [1:0] power_down,      // power down
  input wire logic [1:0] auto_mdi,        // auto crossover result
  input wire logic [1:0] tx_on_rx_pair,   // pair assignment
  input wire logic [1:0] loopback_at_phy  // loopback at phy
);
  import pcl_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_wr_b1;
    reg_wr && reg_addr == PCL_P1_CTL_B_ADDR;
  endsequence
  sequence s_restart_req;
    s_wr_b1 ##0 reg_wdata[PCL_B_RESTART];
  endsequence
  led_blank_a: assert property (s_wr_b1 |=>
    port_led[3:0] == ($past(reg_wdata[7]) ? 4'hf : led_in[3:0])) else $error("led blanking");
  restart_pulse_a: assert property (s_restart_req |=> an_restart[0]) else $error("no pulse");
  restart_clear_a: assert property (an_restart[0] &&
    !(reg_wr && reg_addr == PCL_P1_CTL_B_ADDR && reg_wdata[5]) |=> !an_restart[0])
    else $error("restart stuck");
  forced_dpx_a: assert property (use_forced_dpx == (~autoneg_en | an_failed))
    else $error("forced duplex use");
  fef_gate_a: assert property (s_wr_b1 |=>
    fef_disable == {1'b0, $past(reg_wdata[PCL_B_FEF_DIS])}) else $error("far-end fault");
  mdi_select_a: assert property (s_wr_b1 |=> tx_on_rx_pair[0] ==
    ($past(reg_wdata[2]) ? $past(reg_wdata[1]) : auto_mdi[0])) else $error("pair select");
  port2_ctl_a: assert property (reg_wr && reg_addr == PCL_P2_CTL_B_ADDR |=>
    {tx_disable[1], power_down[1], loopback_at_phy[1]} ==
    {$past(reg_wdata[6]), $past(reg_wdata[3]), $past(reg_wdata[0])}) else $error("port2 ctl");
  forced_mode_a: assert property (reg_wr && reg_addr == PCL_P1_CTL_A_ADDR |=>
    {autoneg_en[0], speed_100[0], full_duplex[0], advertise[4:0]} == $past(reg_wdata))
    else $error("port1 mode");
  reserved_read_a: assert property (reg_rd && reg_addr[7:4] == 4'h3 |=>
    reg_rdata == 8'h00) else $error("reserved read");
endmodule : pcl_link_ctl_chk
bind pcl_link_ctl pcl_link_ctl_chk u_chk (.clk, .rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
  .reg_rdata, .led_in, .port_led, .advertise, .autoneg_en, .speed_100, .full_duplex,
  .use_forced_dpx, .an_failed, .tx_disable, .an_restart, .fef_disable, .power_down,
  .auto_mdi, .tx_on_rx_pair, .loopback_at_phy);

// ---- tb_phy_port_link_control.sv ----
`timescale 1ns/1ps
module tb_phy_port_link_control;
  import pcl_pkg::*;
  logic       clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, led_in = 8'ha5, reg_rdata, port_led;
  logic [1:0] an_failed, auto_mdi, autoneg_en, speed_100, full_duplex, use_forced_dpx;
  logic [1:0] tx_disable, an_restart, fef_disable, power_down, tx_on_rx_pair, loopback_at_phy;
  logic [1:0] fail_cfg = 2'b10, mdi_cfg = 2'b01;
  logic [9:0] advertise;
  logic       first_port_speed_strap = 1'b1, second_port_speed_strap = 1'b0;
  logic       first_port_duplex_strap = 1'b0, second_port_duplex_strap = 1'b1;
  logic       first_port_autoneg_strap = 1'b0, second_port_autoneg_strap = 1'b1;
  logic       pause_advertise_strap = 1'b1, second_port_crossover_disable_strap = 1'b1;
  logic       second_port_crossover_force_strap = 1'b1;
  int         fail_count = 0, num_checks = 0, cyc = 0;
  pcl_link_ctl u_pcl_link_ctl (.clk, .rst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
    .first_port_speed_strap, .second_port_speed_strap, .first_port_duplex_strap,
    .second_port_duplex_strap, .pause_advertise_strap, .second_port_crossover_disable_strap,
    .second_port_crossover_force_strap, .first_port_autoneg_strap, .second_port_autoneg_strap,
    .led_in, .an_failed, .auto_mdi, .port_led, .autoneg_en, .speed_100, .full_duplex,
    .use_forced_dpx, .advertise, .tx_disable, .an_restart, .fef_disable, .power_down,
    .tx_on_rx_pair, .loopback_at_phy);
  pcl_link_partner u_pcl_link_partner (.clk, .rst, .an_restart, .autoneg_en, .fail_cfg,
    .mdi_cfg, .an_failed, .auto_mdi);
  always #5 clk = ~clk;
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : wrap_up
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      fail_count++;
      wrap_up();
    end
  end
  task automatic check(input string name, input logic [9:0] seen, input logic [9:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string name);
    @(negedge clk);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge clk);
    reg_rd = 1'b0;
    check(name, {2'b00, reg_rdata}, {2'b00, exp});
  endtask : rd
  initial begin
    repeat (8) @(negedge clk);
    rst = 1'b0;
    rd(PCL_P1_CTL_A_ADDR, 8'h5f, "p1 ctl_a");
    rd(PCL_P2_CTL_A_ADDR, 8'hbf, "p2 ctl_a");
    rd(PCL_P1_CTL_B_ADDR, 8'h00, "p1 ctl_b");
    rd(PCL_P2_CTL_B_ADDR, 8'h06, "p2 ctl_b");
    check("advertise", advertise, 10'h3ff);
    check("an en", {8'h00, autoneg_en}, 10'h002);
    check("pairs", {8'h00, tx_on_rx_pair}, 10'h003);
    check("forced dpx", {8'h00, use_forced_dpx}, 10'h003);
    wr(PCL_P1_CTL_A_ADDR, 8'h40);
    check("p1 mode", {3'b000, speed_100[0], full_duplex[0], advertise[4:0]}, 10'h040);
    wr(PCL_P1_CTL_A_ADDR, 8'h20);
    check("p1 mode", {3'b000, speed_100[0], full_duplex[0], advertise[4:0]}, 10'h020);
    wr(PCL_P2_CTL_B_ADDR, 8'h20);
    check("restart", {8'h00, an_restart}, 10'h002);
    @(negedge clk);
    check("restart end", {8'h00, an_restart}, 10'h000);
    check("dpx retry", {9'h000, use_forced_dpx[1]}, 10'h000);
    repeat (5) @(negedge clk);
    check("dpx failed", {9'h000, use_forced_dpx[1]}, 10'h001);
    rd(PCL_P2_CTL_B_ADDR, 8'h00, "restart clr");
    wr(PCL_P1_CTL_B_ADDR, 8'h20);
    check("restart p1", {8'h00, an_restart}, 10'h001);
    @(negedge clk);
    check("restart p1 end", {8'h00, an_restart}, 10'h000);
    wr(PCL_P1_CTL_B_ADDR, 8'h80);
    check("led off", {2'b00, port_led}, 10'h0af);
    wr(PCL_P1_CTL_B_ADDR, 8'h00);
    check("led on", {2'b00, port_led}, 10'h0a5);
    wr(PCL_P1_CTL_B_ADDR, 8'h06);
    check("force mdi", {9'h000, tx_on_rx_pair[0]}, 10'h001);
    wr(PCL_P1_CTL_B_ADDR, 8'h04);
    check("force mdix", {9'h000, tx_on_rx_pair[0]}, 10'h000);
    wr(PCL_P1_CTL_B_ADDR, 8'h00);
    check("auto mdi", {9'h000, tx_on_rx_pair[0]}, 10'h001);
    wr(PCL_P2_CTL_B_ADDR, 8'h59);
    check("p2 ctl", {2'b00, tx_disable, fef_disable, power_down, loopback_at_phy}, 10'h08a);
    wr(PCL_P1_CTL_B_ADDR, 8'h11);
    check("fef loop", {6'h00, fef_disable, loopback_at_phy}, 10'h007);
    wr(PCL_P3_CTL_B_ADDR, 8'hff);
    rd(PCL_P3_CTL_B_ADDR, 8'h00, "rsvd b");
    rd(PCL_P3_CTL_A_ADDR, 8'h00, "rsvd a");
    rd(PCL_P1_CTL_B_ADDR, 8'h11, "p1 b kept");
    wr(PCL_P2_CTL_A_ADDR, 8'h3c);
    rd(PCL_P2_CTL_A_ADDR, 8'h3c, "p2 ctl_a");
    // second reset with a changed strap: values must reload from the pins
    @(negedge clk);
    rst = 1'b1;
    first_port_speed_strap = 1'b0;
    repeat (8) @(negedge clk);
    rst = 1'b0;
    rd(PCL_P1_CTL_A_ADDR, 8'h1f, "p1 ctl_a rst2");
    rd(PCL_P1_CTL_B_ADDR, 8'h00, "p1 ctl_b rst2");
    rd(PCL_P2_CTL_B_ADDR, 8'h06, "p2 ctl_b rst2");
    wrap_up();
  end
endmodule : tb_phy_port_link_control
